// file: pkg/pprs_pkg.sv
// Shared constants and types of the paged PHY register space.
// Assumes one clock domain and a single management requester.
package pprs_pkg;

  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int unsigned DATA_W = 16;
  localparam int unsigned IDX_W = 5;

  // ----------------------------------------
  // Register indices
  // ----------------------------------------
  localparam logic [4:0] IDX_MODE_CONTROL = 5'h00;
  localparam logic [4:0] IDX_MODE_STATUS = 5'h01;
  localparam logic [4:0] IDX_IDENT_1 = 5'h02;
  localparam logic [4:0] IDX_IDENT_2 = 5'h03;
  localparam logic [4:0] IDX_AN_ADVERT = 5'h04;
  localparam logic [4:0] IDX_AN_PARTNER = 5'h05;
  localparam logic [4:0] IDX_AN_EXPANSION = 5'h06;
  localparam logic [4:0] IDX_AN_NP_TX = 5'h07;
  localparam logic [4:0] IDX_AN_NP_RX = 5'h08;
  localparam logic [4:0] IDX_GIG_CONTROL = 5'h09;
  localparam logic [4:0] IDX_GIG_STATUS = 5'h0a;
  localparam logic [4:0] IDX_RSVD_A = 5'h0b;
  localparam logic [4:0] IDX_RSVD_B = 5'h0c;
  localparam logic [4:0] IDX_EXTDEV_CONTROL = 5'h0d;
  localparam logic [4:0] IDX_EXTDEV_ADDR_DATA = 5'h0e;
  localparam logic [4:0] IDX_GIG_STATUS_EXT_1 = 5'h0f;
  localparam logic [4:0] IDX_FAST_STATUS_EXT = 5'h10;
  localparam logic [4:0] IDX_GIG_STATUS_EXT_2 = 5'h11;
  localparam logic [4:0] IDX_BYPASS_CONTROL = 5'h12;
  localparam logic [4:0] IDX_RX_ERROR_COUNT = 5'h13;
  localparam logic [4:0] IDX_FALSE_CARRIER_COUNT = 5'h14;
  localparam logic [4:0] IDX_LINK_DISC_COUNT = 5'h15;
  localparam logic [4:0] IDX_EXT_10M = 5'h16;
  localparam logic [4:0] IDX_EXT_PHY_CONTROL_1 = 5'h17;
  localparam logic [4:0] IDX_EXT_PHY_CONTROL_2 = 5'h18;
  localparam logic [4:0] IDX_INT_MASK = 5'h19;
  localparam logic [4:0] IDX_INT_STATUS = 5'h1a;
  localparam logic [4:0] IDX_RSVD_C = 5'h1b;
  localparam logic [4:0] IDX_AUX_CONTROL = 5'h1c;
  localparam logic [4:0] IDX_INDICATOR_MODE = 5'h1d;
  localparam logic [4:0] IDX_INDICATOR_BEHAV = 5'h1e;
  localparam logic [4:0] IDX_PAGE_SELECT = 5'h1f;

  // ----------------------------------------
  // Paging and reset values
  // ----------------------------------------
  localparam logic [4:0] IDX_UPPER_FIRST = 5'h10;
  localparam logic [4:0] IDX_UPPER_LAST = 5'h1e;
  localparam logic [15:0] PAGE_MAIN = 16'h0000;
  localparam logic [15:0] PAGE_EXT_1 = 16'h0001;
  localparam logic [15:0] PAGE_EXT_2 = 16'h0002;
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [1:0] PAGE_CODE_MAIN = 2'h0;
  localparam logic [1:0] PAGE_CODE_EXT_1 = 2'h1;
  localparam logic [1:0] PAGE_CODE_EXT_2 = 2'h2;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic write;
    logic [4:0] index;
    logic [15:0] wdata;
  } pprs_req_t;

  typedef enum logic [1:0] {
    PPRS_IDLE = 2'b01,
    PPRS_ANSWER = 2'b10
  } pprs_state_t;

endpackage

// file: hw/pprs_regs.sv
// Indexed 32-entry PHY register space with main and two extended pages.
// Assumes the MAC management logic issues one request at a time, synchronous
// to clock_in, and waits for the answer pulse before the next request.
//
// Functional notes
// - Space reached only through MAC indirect access.
// - Extended page steers indices 16 to 30.
// - Indices 0 to 15 ignore page select.
// - Writing zero to page select restores main.
// - Page select lives at index 31.
// - Low indices reachable on pages 0,1,2.
// - Decode indices 0 to 8 of main page.
// - Decode gigabit 9,10; keep 11,12 reserved.
// - Decode extended device access at 13,14.
// - Decode status extensions 15-17, bypass 18.
// - Decode error and link counters 19-21.
// - Decode 10 Mb/s and PHY control 22-24.
// - Decode interrupt 25,26; keep 27 reserved.
// - Decode auxiliary and indicator registers 28-30.
// - Registers and transfers are sixteen bits.
`timescale 1ns/1ps

module pprs_regs (
  // Clock and reset.
  input wire logic clock_in,
  input wire logic rstn_in,
  // Management request from the MAC access logic.
  input wire logic req_valid_in,
  input wire pprs_pkg::pprs_req_t req_in,
  // Answer to the MAC access logic.
  output logic ack_out,
  output logic [15:0] rdata_out,
  // Currently selected page.
  output logic [1:0] page_out
);

  // ----------------------------------------
  // Request handshake
  // ----------------------------------------

  pprs_pkg::pprs_state_t state;
  pprs_pkg::pprs_state_t next_state;
  logic take;

  // A request is only taken while idle, so the answer cycle refuses input.
  assign take = req_valid_in && (state == pprs_pkg::PPRS_IDLE);

  // Two-state sequencer: take a request, then answer it for one cycle.
  always_comb begin
    case (state)
      pprs_pkg::PPRS_IDLE: begin
        next_state = take ? pprs_pkg::PPRS_ANSWER : pprs_pkg::PPRS_IDLE;
      end
      pprs_pkg::PPRS_ANSWER: begin
        next_state = pprs_pkg::PPRS_IDLE;
      end
      default: begin
        next_state = pprs_pkg::PPRS_IDLE;
      end
    endcase
  end

  // State register.
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state <= pprs_pkg::PPRS_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------
  // Index decode
  // ----------------------------------------

  logic [4:0] idx;
  logic hit_ieee_low;
  logic hit_gig;
  logic hit_extdev;
  logic hit_status_ext;
  logic hit_counters;
  logic hit_ext_control;
  logic hit_interrupt;
  logic hit_indicator;
  logic hit_page_select;
  logic hit_main_reg;
  logic hit_reserved;
  logic in_upper;

  assign idx = req_in.index;

  // Mode control, status, identifiers and auto-negotiation words 0 to 8.
  assign hit_ieee_low = (idx <= pprs_pkg::IDX_AN_NP_RX);
  // Gigabit control and status.
  assign hit_gig = (idx == pprs_pkg::IDX_GIG_CONTROL) ||
                   (idx == pprs_pkg::IDX_GIG_STATUS);
  // Extended device access control and address/data words.
  assign hit_extdev = (idx == pprs_pkg::IDX_EXTDEV_CONTROL) ||
                      (idx == pprs_pkg::IDX_EXTDEV_ADDR_DATA);
  // Status extensions and bypass control.
  assign hit_status_ext = (idx == pprs_pkg::IDX_GIG_STATUS_EXT_1) ||
                          (idx == pprs_pkg::IDX_FAST_STATUS_EXT) ||
                          (idx == pprs_pkg::IDX_GIG_STATUS_EXT_2) ||
                          (idx == pprs_pkg::IDX_BYPASS_CONTROL);
  // Receive error, false carrier and link disconnect counters.
  assign hit_counters = (idx == pprs_pkg::IDX_RX_ERROR_COUNT) ||
                        (idx == pprs_pkg::IDX_FALSE_CARRIER_COUNT) ||
                        (idx == pprs_pkg::IDX_LINK_DISC_COUNT);
  // Extended 10 Mb/s word and the two extended PHY control words.
  assign hit_ext_control = (idx == pprs_pkg::IDX_EXT_10M) ||
                           (idx == pprs_pkg::IDX_EXT_PHY_CONTROL_1) ||
                           (idx == pprs_pkg::IDX_EXT_PHY_CONTROL_2);
  // Interrupt mask and status.
  assign hit_interrupt = (idx == pprs_pkg::IDX_INT_MASK) ||
                         (idx == pprs_pkg::IDX_INT_STATUS);
  // Auxiliary control and the two indicator words.
  assign hit_indicator = (idx == pprs_pkg::IDX_AUX_CONTROL) ||
                         (idx == pprs_pkg::IDX_INDICATOR_MODE) ||
                         (idx == pprs_pkg::IDX_INDICATOR_BEHAV);
  // Page select sits at the top index.
  assign hit_page_select = (idx == pprs_pkg::IDX_PAGE_SELECT);
  // Every index that names a main page register; the gaps are reserved.
  assign hit_main_reg = hit_ieee_low || hit_gig || hit_extdev || hit_status_ext ||
                        hit_counters || hit_ext_control || hit_interrupt || hit_indicator;

  // Upper range that the page select can redirect.
  assign in_upper = (idx >= pprs_pkg::IDX_UPPER_FIRST) &&
                    (idx <= pprs_pkg::IDX_UPPER_LAST);

  // ----------------------------------------
  // Page selection
  // ----------------------------------------

  logic [15:0] page_select;
  logic sel_ext_1;
  logic sel_ext_2;
  logic ext_active;
  logic [1:0] next_page_code;

  // Only the page select word decides where the upper range goes.
  assign sel_ext_1 = (page_select == pprs_pkg::PAGE_EXT_1);
  assign sel_ext_2 = (page_select == pprs_pkg::PAGE_EXT_2);
  assign ext_active = sel_ext_1 || sel_ext_2;
  // Any other value, zero among them, falls back to the main page.
  assign next_page_code = sel_ext_1 ? pprs_pkg::PAGE_CODE_EXT_1 :
                          sel_ext_2 ? pprs_pkg::PAGE_CODE_EXT_2 :
                          pprs_pkg::PAGE_CODE_MAIN;

  // Gaps in the main page map are reserved while the main page is reached.
  // On an extended page the whole upper range is plain storage.
  assign hit_reserved = !hit_main_reg && !hit_page_select &&
                        (!in_upper || !ext_active);

  logic page_wr;
  logic main_route;

  assign page_wr = take && req_in.write && hit_page_select;
  // Low indices always reach the main page; upper ones only on page 0.
  assign main_route = !in_upper || !ext_active;

  // Page select register; it also drives the page code output.
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      page_select <= pprs_pkg::PAGE_MAIN;
    end else if (page_wr) begin
      page_select <= req_in.wdata;
    end
  end

  // Page code output follows the stored page select one cycle later.
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      page_out <= pprs_pkg::PAGE_CODE_MAIN;
    end else begin
      page_out <= next_page_code;
    end
  end

  // ----------------------------------------
  // Register storage
  // ----------------------------------------

  logic [15:0] main_mem [0:30];
  logic [15:0] ext1_mem [16:30];
  logic [15:0] ext2_mem [16:30];
  logic main_wr;
  logic ext1_wr;
  logic ext2_wr;

  // Write strobes per page, reserved indices excluded.
  assign main_wr = take && req_in.write && !hit_reserved &&
                   !hit_page_select && main_route;
  assign ext1_wr = take && req_in.write && in_upper && sel_ext_1;
  assign ext2_wr = take && req_in.write && in_upper && sel_ext_2;

  // One sixteen-bit word per main page entry, written by index.
  for (genvar i = 0; i <= 30; i++) begin : g_main
    always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
        main_mem[i] <= pprs_pkg::REG_RESET;
      end else if (main_wr && (idx == 5'(i))) begin
        main_mem[i] <= req_in.wdata;
      end
    end
  end

  // Extended pages hold only the upper index range.
  for (genvar j = 16; j <= 30; j++) begin : g_ext
    always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
        ext1_mem[j] <= pprs_pkg::REG_RESET;
        ext2_mem[j] <= pprs_pkg::REG_RESET;
      end else begin
        if (ext1_wr && (idx == 5'(j))) begin
          ext1_mem[j] <= req_in.wdata;
        end
        if (ext2_wr && (idx == 5'(j))) begin
          ext2_mem[j] <= req_in.wdata;
        end
      end
    end
  end

  // ----------------------------------------
  // Read selection
  // ----------------------------------------

  logic [15:0] main_word;
  logic [15:0] ext1_word;
  logic [15:0] ext2_word;
  logic [15:0] read_word;
  logic [15:0] next_rdata;

  // Array reads are guarded below so that an out-of-range index is never used.
  assign main_word = hit_page_select ? pprs_pkg::REG_RESET : main_mem[idx];
  assign ext1_word = in_upper ? ext1_mem[idx] : pprs_pkg::REG_RESET;
  assign ext2_word = in_upper ? ext2_mem[idx] : pprs_pkg::REG_RESET;

  // Reserved reads zero; page select reads itself; otherwise page steering.
  assign read_word = hit_reserved ? pprs_pkg::REG_RESET :
                     hit_page_select ? page_select :
                     (in_upper && sel_ext_1) ? ext1_word :
                     (in_upper && sel_ext_2) ? ext2_word :
                     main_word;
  // Write answers carry zero data.
  assign next_rdata = (take && !req_in.write) ? read_word : pprs_pkg::REG_RESET;

  // Answer registers: one-cycle acknowledge with its read data.
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ack_out <= 1'b0;
      rdata_out <= pprs_pkg::REG_RESET;
    end else begin
      ack_out <= take;
      rdata_out <= next_rdata;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------

  // Every taken request is answered on the next edge.
  a_ack_after_take: assert property (
    @(posedge clock_in) disable iff (!rstn_in)
    take |=> ack_out ##1 !ack_out)
    else $error("Taken request not answered in exactly one cycle.");

  // No answer appears without a request taken before it.
  a_ack_has_cause: assert property (
    @(posedge clock_in) disable iff (!rstn_in)
    ack_out |-> $past(take))
    else $error("Answer without a taken request.");

  // Zero written to page select brings the main page back.
  a_page_zero_main: assert property (
    @(posedge clock_in) disable iff (!rstn_in)
    (page_wr && (req_in.wdata == pprs_pkg::PAGE_MAIN)) |=> ##1
    (page_out == pprs_pkg::PAGE_CODE_MAIN))
    else $error("Page zero write did not restore the main page.");

  // Writing two to page select reports page two, two edges later.
  a_page_ext_code: assert property (
    @(posedge clock_in) disable iff (!rstn_in)
    (page_wr && (req_in.wdata == pprs_pkg::PAGE_EXT_2)) |=> ##1
    (page_out == pprs_pkg::PAGE_CODE_EXT_2))
    else $error("Page select value two not reported.");

  // Writing one to page select reports page one, two edges later.
  a_page_one_code: assert property (
    @(posedge clock_in) disable iff (!rstn_in)
    (page_wr && (req_in.wdata == pprs_pkg::PAGE_EXT_1)) |=> ##1
    (page_out == pprs_pkg::PAGE_CODE_EXT_1))
    else $error("Page select value one not reported.");

  // Write answers carry zero data.
  a_write_data_zero: assert property (
    @(posedge clock_in) disable iff (!rstn_in)
    (take && req_in.write) |=> (rdata_out == pprs_pkg::REG_RESET))
    else $error("Write answer carried nonzero data.");

  // Outside an answer the read data lines rest at zero.
  a_idle_data_zero: assert property (
    @(posedge clock_in) disable iff (!rstn_in)
    !ack_out |-> (rdata_out == pprs_pkg::REG_RESET))
    else $error("Read data moved without an answer.");

  // Low index reads on an extended page still return the main word.
  a_low_read_main: assert property (
    @(posedge clock_in) disable iff (!rstn_in)
    (take && !req_in.write && !in_upper && !hit_page_select && !hit_reserved &&
     ext_active) |=> (rdata_out == $past(main_word)))
    else $error("Low index read did not reach the main page.");

  // Upper reads on page one return the extended word.
  a_ext_read_page: assert property (
    @(posedge clock_in) disable iff (!rstn_in)
    (take && !req_in.write && in_upper && sel_ext_1) |=>
    (rdata_out == $past(ext1_word)))
    else $error("Upper read on page one missed the extended word.");

  // Upper writes on an extended page leave the main word alone.
  a_ext_write_routed: assert property (
    @(posedge clock_in) disable iff (!rstn_in)
    (take && req_in.write && in_upper && ext_active) |=>
    (main_mem[$past(idx)] == $past(main_word)))
    else $error("Extended page write reached the main page.");

  // Reserved reads answer zero.
  a_reserved_zero: assert property (
    @(posedge clock_in) disable iff (!rstn_in)
    (take && !req_in.write && hit_reserved) |=> (rdata_out == 16'h0000))
    else $error("Reserved index read was not zero.");

  // Reserved main entries never hold anything but zero.
  a_reserved_store: assert property (
    @(posedge clock_in) disable iff (!rstn_in)
    (main_mem[pprs_pkg::IDX_RSVD_A] == pprs_pkg::REG_RESET) &&
    (main_mem[pprs_pkg::IDX_RSVD_B] == pprs_pkg::REG_RESET) &&
    (main_mem[pprs_pkg::IDX_RSVD_C] == pprs_pkg::REG_RESET))
    else $error("Reserved entry took a write.");

  // The sequencer state stays one-hot.
  a_state_onehot: assert property (
    @(posedge clock_in) disable iff (!rstn_in)
    $onehot(state))
    else $error("Sequencer state is not one-hot.");

endmodule

// file: verif/pprs_mac_model.sv
// MAC-side management access model that drives the paged PHY register space.
// Assumes the bench calls xfer from one thread, one transfer at a time.
`timescale 1ns/1ps

module pprs_mac_model (
  // Clock.
  input wire logic clock_in,
  // Answer from the register space.
  input wire logic ack_in,
  input wire logic [15:0] rdata_in,
  // Request toward the register space.
  output logic req_valid_out,
  output pprs_pkg::pprs_req_t req_out
);
  // ----------------------------------------
  // Indirect transfer
  // ----------------------------------------
  // Requests start idle so the design sees known inputs from time zero.
  initial begin
    req_valid_out <= 1'b0;
    req_out <= '0;
  end

  // One 16-bit word per call; the request stands until the edge that samples
  // the answer high, which the device refuses as a second take. The answer is
  // awaited for a few cycles only, so a silent device cannot hang the run.
  task automatic xfer(input logic wr, input logic [4:0] idx, input logic [15:0] wd,
                      output logic [15:0] rd, output logic seen);
    int n;
    @(negedge clock_in);
    req_valid_out <= 1'b1;
    req_out <= '{write: wr, index: idx, wdata: wd};
    rd = 16'h0000;
    seen = 1'b0;
    for (n = 0; n < 4 && !seen; n++) begin
      @(posedge clock_in);
      if (ack_in === 1'b1) begin
        rd = rdata_in;
        seen = 1'b1;
      end
    end
    // Released lines never keep the last value.
    req_valid_out <= 1'b0;
    req_out <= ~req_out;
  endtask
endmodule

// file: verif/pprs_regs_tb_top.sv
// Self-checking bench for the paged PHY register space.
// Assumes the MAC model in its own file and the shared package compiled first.
`timescale 1ns/1ps

module pprs_regs_tb_top;
  // ----------------------------------------
  // Signals and reference state
  // ----------------------------------------
  logic clock_in, rstn_in, req_valid_in, ack_out;
  pprs_pkg::pprs_req_t req_in;
  logic [15:0] rdata_out;
  logic [1:0] page_out;
  logic [15:0] mem [0:2][0:31];
  logic [15:0] psel;
  int n_fail, num_checks;

  // Clock at 50 MHz.
  initial begin
    clock_in = 1'b0;
    forever #10 clock_in = ~clock_in;
  end

  pprs_regs u_pprs_regs (.clock_in(clock_in), .rstn_in(rstn_in), .req_valid_in(req_valid_in),
    .req_in(req_in), .ack_out(ack_out), .rdata_out(rdata_out), .page_out(page_out));
  pprs_mac_model u_pprs_mac_model (.clock_in(clock_in), .ack_in(ack_out),
    .rdata_in(rdata_out), .req_valid_out(req_valid_in), .req_out(req_in));

  // ----------------------------------------
  // Expectation functions
  // ----------------------------------------
  // Page code that a stored page-select word stands for.
  function automatic logic [1:0] code_of(input logic [15:0] v);
    return (v == pprs_pkg::PAGE_EXT_1) ? pprs_pkg::PAGE_CODE_EXT_1 :
           (v == pprs_pkg::PAGE_EXT_2) ? pprs_pkg::PAGE_CODE_EXT_2 : pprs_pkg::PAGE_CODE_MAIN;
  endfunction

  // Bank an index reaches under the current page select.
  function automatic logic [1:0] bank_of(input logic [4:0] idx);
    return (idx >= pprs_pkg::IDX_UPPER_FIRST && idx <= pprs_pkg::IDX_UPPER_LAST) ?
           code_of(psel) : pprs_pkg::PAGE_CODE_MAIN;
  endfunction

  // Reserved places exist on the main page only.
  function automatic logic rsvd(input logic [4:0] idx);
    return bank_of(idx) == pprs_pkg::PAGE_CODE_MAIN && (idx == pprs_pkg::IDX_RSVD_A ||
           idx == pprs_pkg::IDX_RSVD_B || idx == pprs_pkg::IDX_RSVD_C);
  endfunction

  // ----------------------------------------
  // Compare and transfer tasks
  // ----------------------------------------
  // Compares one answer word.
  task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t word got %h exp %h", $time, got, exp);
    end
  endtask

  // Compares the page code output.
  task automatic check_page(input logic [1:0] got, input logic [1:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t page got %h exp %h", $time, got, exp);
    end
  endtask

  // One transfer with its expected answer, then the page code once it settled.
  task automatic op(input logic wr, input logic [4:0] idx, input logic [15:0] wd);
    logic [15:0] rd, want;
    logic seen;
    want = (wr || rsvd(idx)) ? 16'h0000 :
           (idx == pprs_pkg::IDX_PAGE_SELECT) ? psel : mem[bank_of(idx)][idx];
    u_pprs_mac_model.xfer(wr, idx, wd, rd, seen);
    check_word({15'h0000, seen}, 16'h0001);
    check_word(rd, want);
    if (wr && !rsvd(idx)) begin
      if (idx == pprs_pkg::IDX_PAGE_SELECT) psel = wd;
      else mem[bank_of(idx)][idx] = wd;
    end
    @(negedge clock_in);
    check_page(page_out, code_of(psel));
  endtask

  // Clears the reference to its reset state.
  task automatic ref_reset;
    psel = pprs_pkg::REG_RESET;
    foreach (mem[p, i]) mem[p][i] = pprs_pkg::REG_RESET;
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  // Runs reset sweep, page sweeps, random traffic and a second reset.
  initial begin
    int i, p, n;
    logic [31:0] r;
    void'($urandom(63));
    n_fail = 0;
    num_checks = 0;
    rstn_in = 1'b0;
    ref_reset();
    repeat (5) @(negedge clock_in);
    rstn_in = 1'b1;
    for (i = 0; i < 32; i++) op(1'b0, i[4:0], 16'h0000);
    for (p = 0; p < 3; p++) begin
      op(1'b1, pprs_pkg::IDX_PAGE_SELECT, 16'(p));
      for (i = 0; i < 31; i++) op(1'b1, i[4:0], 16'($urandom));
      for (i = 0; i < 32; i++) op(1'b0, i[4:0], 16'h0000);
    end
    op(1'b1, pprs_pkg::IDX_PAGE_SELECT, pprs_pkg::PAGE_MAIN);
    for (i = 0; i < 32; i++) op(1'b0, i[4:0], 16'h0000);
    for (n = 0; n < 300; n++) begin
      r = $urandom;
      if (r[2:0] == 3'h0) op(1'b1, 5'h1f, r[3] ? {14'h0000, r[5:4]} : r[31:16]);
      else op(r[8], r[13:9], r[31:16]);
    end
    rstn_in = 1'b0;
    repeat (2) @(negedge clock_in);
    rstn_in = 1'b1;
    ref_reset();
    check_page(page_out, pprs_pkg::PAGE_CODE_MAIN);
    for (i = 0; i < 32; i++) op(1'b0, i[4:0], 16'h0000);
    wrap_up();
  end

  // Cuts a hang short at 60000 cycles, well beyond the expected run of about 1800 cycles.
  initial begin
    #(20 * 60000);
    n_fail++;
    wrap_up();
  end
endmodule
